// ### logic/mcp_top.sv
// Bank of six independent square-wave channels with shared clock sampling,
// synchronised group update and pairwise output inversion.
// Assumes configuration, trigger and sync_load come from logic on clk, and
// that the PLL and crystal clocks arrive as plain inputs from another domain.
//
// Contract
// - There are six channels, each running on its own settings and state.
// - Each channel makes a square wave whose duty comes from software settings.
// - Each channel times its phases by counting edges of its chosen input clock.
// - High and low phase lengths come from two separate 16-bit divide values.
// - Channels run alone or in a synchronised group whose new settings start together.
// - Within each channel pair, the second output may be inverted for a differential pair.
// - Each channel repeats its phases continuously or gives one pulse per trigger.
// - Each channel counts either the PLL clock or the crystal-rate clock.
module mcp_top (
	input  wire logic                            clk,       // System clock, 25 MHz.
	input  wire logic                            rstn,      // Asynchronous reset, active low.
	input  wire logic                            pll_clk,   // PLL clock, sampled as data.
	input  wire logic                            xo_clk,    // Crystal-rate clock, sampled as data.
	input  wire mcp_pkg::mcp_cfg_s [mcp_pkg::NCH-1:0] cfg,  // Per-channel settings.
	input  wire logic [mcp_pkg::NCH-1:0]         trig,      // Single pulse start, one cycle.
	input  wire logic                            sync_load, // Capture group settings, one cycle.
	input  wire logic [mcp_pkg::NPAIR-1:0]       pair_inv,  // Invert odd output of each pair.
	output logic [mcp_pkg::NCH-1:0]              pwm_out,   // Channel outputs.
	output logic [mcp_pkg::NCH-1:0]              busy,      // Channel is producing a waveform.
	output logic                                 sync_busy  // Group update still waiting.
);

	mcp_pkg::mcp_top_st_s      r_reg;
	mcp_pkg::mcp_top_st_s      r_next;
	logic [mcp_pkg::NCH-1:0]   ch_wave;
	logic [mcp_pkg::NCH-1:0]   ch_parked;
	logic [mcp_pkg::NCH-1:0]   ch_busy;
	logic [mcp_pkg::NCH-1:0]   grp_member;
	logic                      grp_ready;
	logic [mcp_pkg::NCH-1:0]   out_next;

	// New sampled level of an outside clock: it changes only once the second
	// and third stages agree, so a sampling glitch never makes a tick.
	function automatic logic mcp_level(input logic [mcp_pkg::SYNC_W-1:0] sy,
		input logic lvl);
		logic res;
		res = lvl;
		if (sy[1] == sy[2]) begin
			res = sy[2];
		end
		return res;
	endfunction : mcp_level

	// Channels taking part in the pending group update.
	assign grp_member = {mcp_pkg::NCH{1'b0}} | out_member(cfg);

	function automatic logic [mcp_pkg::NCH-1:0] out_member(
		input mcp_pkg::mcp_cfg_s [mcp_pkg::NCH-1:0] c);
		logic [mcp_pkg::NCH-1:0] m;
		m = '0;
		for (int i = 0; i < mcp_pkg::NCH; i++) begin
			m[i] = c[i].en && c[i].sync_mode;
		end
		return m;
	endfunction : out_member

	// The group starts only when every member has finished its current period,
	// so none of them is cut short. A member that never reaches its period end
	// (a very long divider) holds the others parked meanwhile.
	assign grp_ready = &(ch_parked | ~grp_member);

	// Pairwise inversion on the odd channel of each pair; the even one is untouched.
	generate
		for (genvar p = 0; p < mcp_pkg::NPAIR; p++) begin : g_pair
			assign out_next[2*p]   = ch_wave[2*p];
			assign out_next[2*p+1] = ch_wave[2*p+1] ^ pair_inv[p];
		end
	endgenerate

	// Next state of the bank: clock sampling, group staging and output stage.
	always_comb begin
		r_next = r_reg;
		// Three-stage sampling of both outside clocks. The PLL clock must stay
		// below a quarter of the system clock rate or its edges are lost here.
		r_next.pll_sy   = {r_reg.pll_sy[1:0], pll_clk};
		r_next.xo_sy    = {r_reg.xo_sy[1:0], xo_clk};
		r_next.pll_lvl  = mcp_level(r_reg.pll_sy, r_reg.pll_lvl);
		r_next.xo_lvl   = mcp_level(r_reg.xo_sy, r_reg.xo_lvl);
		r_next.pll_tick = r_next.pll_lvl && !r_reg.pll_lvl;
		r_next.xo_tick  = r_next.xo_lvl && !r_reg.xo_lvl;

		// Group release lasts one cycle and disarms the request.
		r_next.release_p = 1'b0;
		if (r_reg.armed && !r_reg.release_p && grp_ready) begin
			r_next.release_p = 1'b1;
			r_next.armed     = 1'b0;
		end

		// A load wins over a release in the same cycle: the fresh settings are
		// staged and the group waits again, so no request is lost.
		if (sync_load) begin
			for (int i = 0; i < mcp_pkg::NCH; i++) begin
				if (cfg[i].sync_mode) begin
					r_next.staged[i] = '{clk_sel: cfg[i].clk_sel,
						hi_div: cfg[i].hi_div, lo_div: cfg[i].lo_div};
				end
			end
			r_next.armed     = 1'b1;
			r_next.release_p = 1'b0;
		end

		// Outputs leave from flip-flops.
		r_next.pwm_out   = out_next;
		r_next.busy      = ch_busy;
		r_next.sync_busy = r_next.armed;
	end

	// State register of the bank.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '{pll_sy: mcp_pkg::SYNC_RST, xo_sy: mcp_pkg::SYNC_RST,
				pll_lvl: 1'b0, xo_lvl: 1'b0, pll_tick: 1'b0, xo_tick: 1'b0,
				armed: 1'b0, release_p: 1'b0, staged: '0, pwm_out: '0,
				busy: '0, sync_busy: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// One sequencer per channel, each with its own settings and state.
	generate
		for (genvar c = 0; c < mcp_pkg::NCH; c++) begin : g_chan
			mcp_chan u_chan (
				.clk       (clk),
				.rstn      (rstn),
				.cfg       (cfg[c]),
				.staged    (r_reg.staged[c]),
				.pll_tick  (r_reg.pll_tick),
				.xo_tick   (r_reg.xo_tick),
				.trig      (trig[c]),
				.sync_pend (r_reg.armed),
				.release_p (r_reg.release_p),
				.wave      (ch_wave[c]),
				.parked    (ch_parked[c]),
				.busy      (ch_busy[c])
			);
		end
	endgenerate

	// Registered outputs.
	assign pwm_out   = r_reg.pwm_out;
	assign busy      = r_reg.busy;
	assign sync_busy = r_reg.sync_busy;

endmodule : mcp_top

// ### shared/mcp_pkg.sv
// Shared constants and types for the six-channel square-wave generator bank.
// Assumes every user of it writes mcp_pkg::name and imports nothing.
package mcp_pkg;

	// Bank geometry.
	localparam int NCH   = 6;
	localparam int NPAIR = 3;
	localparam int DIV_W = 16;
	localparam int SYNC_W = 3;

	// Input clock select encoding: high picks the PLL clock, low the crystal clock.
	localparam logic CLK_PLL = 1'b1;
	localparam logic CLK_XO  = 1'b0;

	// Reset values.
	localparam logic [DIV_W-1:0] DIV_RST  = 16'h0000;
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;

	// Per-channel configuration as software presents it.
	typedef struct packed {
		logic             en;        // Channel enabled.
		logic             single;    // One pulse per trigger instead of continuous.
		logic             clk_sel;   // Input clock select.
		logic             sync_mode; // Settings take effect with the synchronised group.
		logic [DIV_W-1:0] hi_div;    // High phase lasts hi_div+1 input clock cycles.
		logic [DIV_W-1:0] lo_div;    // Low phase lasts lo_div+1 input clock cycles.
	} mcp_cfg_s;

	// Settings a channel actually runs with.
	typedef struct packed {
		logic             clk_sel;
		logic [DIV_W-1:0] hi_div;
		logic [DIV_W-1:0] lo_div;
	} mcp_act_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HIGH,
		ST_LOW,
		ST_PARK
	} mcp_state_e;

	// Complete state of one channel.
	typedef struct packed {
		mcp_state_e       state;
		mcp_act_s         act;
		logic [DIV_W-1:0] cnt;
		logic             wave;
	} mcp_chan_st_s;

	// Complete state of the bank top.
	typedef struct packed {
		logic [SYNC_W-1:0]    pll_sy;
		logic [SYNC_W-1:0]    xo_sy;
		logic                 pll_lvl;
		logic                 xo_lvl;
		logic                 pll_tick;
		logic                 xo_tick;
		logic                 armed;
		logic                 release_p;
		mcp_act_s [NCH-1:0]   staged;
		logic [NCH-1:0]       pwm_out;
		logic [NCH-1:0]       busy;
		logic                 sync_busy;
	} mcp_top_st_s;

endpackage : mcp_pkg

// ### logic/mcp_chan.sv
// One square-wave channel: high phase, low phase, optional single pulse.
// Assumes the ticks are one-cycle pulses on clk and that the top sequences
// the synchronised group through sync_pend and release_p.
module mcp_chan (
	input  wire logic              clk,       // System clock.
	input  wire logic              rstn,      // Asynchronous reset, active low.
	input  wire mcp_pkg::mcp_cfg_s cfg,       // Live configuration.
	input  wire mcp_pkg::mcp_act_s staged,    // Settings captured for the group.
	input  wire logic              pll_tick,  // One edge of the PLL clock.
	input  wire logic              xo_tick,   // One edge of the crystal clock.
	input  wire logic              trig,      // Single pulse start request.
	input  wire logic              sync_pend, // Group update is waiting.
	input  wire logic              release_p, // Group starts together now.
	output logic                   wave,      // Raw channel waveform.
	output logic                   parked,    // Channel is at a safe boundary.
	output logic                   busy       // Channel is producing a waveform.
);

	mcp_pkg::mcp_chan_st_s r_reg;
	mcp_pkg::mcp_chan_st_s r_next;
	mcp_pkg::mcp_act_s     live;
	mcp_pkg::mcp_act_s     src;
	logic                  tick;

	// Live settings and the set a fresh start uses.
	assign live = '{clk_sel: cfg.clk_sel, hi_div: cfg.hi_div, lo_div: cfg.lo_div};
	assign src  = cfg.sync_mode ? staged : live;

	// The running clock choice is latched with the dividers so a select change
	// cannot shorten a phase in flight.
	assign tick = (r_reg.act.clk_sel == mcp_pkg::CLK_PLL) ? pll_tick : xo_tick;

	// Phase sequencer.
	always_comb begin
		r_next = r_reg;
		case (r_reg.state)
			mcp_pkg::ST_IDLE: begin
				if (cfg.en && (!cfg.single || trig)) begin
					r_next.act   = src;
					r_next.cnt   = mcp_pkg::DIV_RST;
					r_next.state = mcp_pkg::ST_HIGH;
					r_next.wave  = 1'b1;
				end
			end
			mcp_pkg::ST_HIGH: begin
				if (tick) begin
					if (r_reg.cnt == r_reg.act.hi_div) begin
						r_next.cnt   = mcp_pkg::DIV_RST;
						r_next.state = mcp_pkg::ST_LOW;
						r_next.wave  = 1'b0;
					end else begin
						r_next.cnt = r_reg.cnt + 16'h0001;
					end
				end
			end
			mcp_pkg::ST_LOW: begin
				if (tick) begin
					if (r_reg.cnt == r_reg.act.lo_div) begin
						r_next.cnt = mcp_pkg::DIV_RST;
						if (cfg.single) begin
							r_next.state = mcp_pkg::ST_IDLE;
						end else if (cfg.sync_mode && sync_pend) begin
							r_next.state = mcp_pkg::ST_PARK;
						end else begin
							// Only the period end picks up new dividers.
							if (!cfg.sync_mode) begin
								r_next.act = live;
							end
							r_next.state = mcp_pkg::ST_HIGH;
							r_next.wave  = 1'b1;
						end
					end else begin
						r_next.cnt = r_reg.cnt + 16'h0001;
					end
				end
			end
			mcp_pkg::ST_PARK: begin
				if (release_p) begin
					r_next.act   = staged;
					r_next.state = mcp_pkg::ST_HIGH;
					r_next.wave  = 1'b1;
				end
			end
			default: begin
				r_next.state = mcp_pkg::ST_IDLE;
			end
		endcase
		// Disabling stops at once; the output rests low.
		if (!cfg.en) begin
			r_next.state = mcp_pkg::ST_IDLE;
			r_next.cnt   = mcp_pkg::DIV_RST;
			r_next.wave  = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '{state: mcp_pkg::ST_IDLE, act: '0, cnt: mcp_pkg::DIV_RST, wave: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// Status views of the sequencer.
	assign wave   = r_reg.wave;
	assign parked = (r_reg.state == mcp_pkg::ST_PARK) || (r_reg.state == mcp_pkg::ST_IDLE);
	assign busy   = (r_reg.state != mcp_pkg::ST_IDLE);

endmodule : mcp_chan

// ### test/mcp_top_asserts.sv
// Concurrent checks on the ports of the square-wave bank top.
// Assumes one clock domain, clk, with rstn asynchronous and active low.
module mcp_top_asserts (
	input wire logic                                 clk,       // System clock.
	input wire logic                                 rstn,      // Reset, active low.
	input wire mcp_pkg::mcp_cfg_s [mcp_pkg::NCH-1:0] cfg,       // Channel settings.
	input wire logic [mcp_pkg::NCH-1:0]              trig,      // Single pulse starts.
	input wire logic                                 sync_load, // Group capture.
	input wire logic [mcp_pkg::NPAIR-1:0]            pair_inv,  // Pair inversion.
	input wire logic [mcp_pkg::NCH-1:0]              pwm_out,   // Channel outputs.
	input wire logic [mcp_pkg::NCH-1:0]              busy,      // Channel running.
	input wire logic                                 sync_busy  // Group waiting.
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Group bookkeeping: armed only by a load, never released in a load cycle.
	a_group_armed: assert property (sync_load |=> sync_busy)
		else $error("group not armed after load");
	a_arm_cause: assert property ($rose(sync_busy) |-> $past(sync_load))
		else $error("group armed without load");
	a_release_clean: assert property ($fell(sync_busy) |-> !$past(sync_load))
		else $error("group released despite load");
	// A disabled channel goes low; an idle inverted odd output rests high.
	a_idle_low: assert property (!cfg[0].en [*2] |=> !pwm_out[0])
		else $error("disabled channel still high");
	a_pair_invert: assert property ((!cfg[1].en && pair_inv[0]) [*3] |=> pwm_out[1])
		else $error("idle inverted output not high");
	// A trigger on a quiet single channel shows as a rising output two cycles on.
	a_trig_start: assert property ((cfg[0].en && cfg[0].single && !cfg[0].sync_mode
		&& !trig[0] && !busy[0]) [*3] ##1 (trig[0] && cfg[0].en && cfg[0].single
		&& !cfg[0].sync_mode) |-> ##2 pwm_out[0])
		else $error("single pulse did not start");
	a_pulse_rest: assert property ($fell(busy[0]) && $past(cfg[0].single && !trig[0])
		|=> !pwm_out[0])
		else $error("output not low after pulse");
	a_out_busy: assert property ($rose(pwm_out[0]) |-> busy[0])
		else $error("output rose on idle channel");
endmodule : mcp_top_asserts

bind mcp_top mcp_top_asserts mcp_top_asserts_i (.clk, .rstn, .cfg, .trig, .sync_load,
	.pair_inv, .pwm_out, .busy, .sync_busy);

// ### test/mcp_load.sv
// Behavioural loads on the six outputs, timing each phase in clk cycles.
// Assumes outputs change only just after rising edges of clk.
module mcp_load (
	input  wire logic       clk,        // System clock.
	input  wire logic       rstn,       // Reset, active low.
	input  wire logic [5:0] pwm_out,    // Waveforms reaching the loads.
	output int              hi_len [6], // Last whole high phase, cycles.
	output int              lo_len [6], // Last whole low phase, cycles.
	output int              rises [6]   // Rising edges seen.
);
	timeunit 1ns;
	timeprecision 1ps;
	int         run [6];
	logic [5:0] last;
	// A phase is only recorded once it ends; a cut-short first phase is recorded too, until a later phase replaces it.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			last <= '0;
			run <= '{default: 0};
			rises <= '{default: 0};
			hi_len <= '{default: 0};
			lo_len <= '{default: 0};
		end else begin
			last <= pwm_out;
			for (int k = 0; k < 6; k++) begin
				run[k] <= (pwm_out[k] != last[k]) ? 1 : run[k] + 1;
				if (pwm_out[k] && !last[k]) begin
					rises[k] <= rises[k] + 1;
					lo_len[k] <= run[k];
				end
				if (!pwm_out[k] && last[k]) begin
					hi_len[k] <= run[k];
				end
			end
		end
	end
endmodule : mcp_load

// ### test/testbench.sv
// Self-checking bench for the square-wave bank with random dividers.
// Assumes the design, the load model and the checker are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk, rstn, pll_clk, xo_clk, sync_load, sync_busy;
	mcp_pkg::mcp_cfg_s [5:0] cfg;
	logic [5:0]              trig, pwm_out, busy;
	logic [2:0]              pair_inv;
	int                      fail_count = 0, n_tests = 0, cyc = 0, n;
	int                      hi_len [6], lo_len [6], rises [6], r0 [6];

	mcp_top mcp_top_i (.clk, .rstn, .pll_clk, .xo_clk, .cfg, .trig, .sync_load,
		.pair_inv, .pwm_out, .busy, .sync_busy);
	mcp_load mcp_load_i (.clk, .rstn, .pwm_out, .hi_len, .lo_len, .rises);

	// System clock, 40 ns period.
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	// Input clocks are made on clk so a tick period is an exact cycle count.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 2 == 0) xo_clk <= ~xo_clk;
		if (cyc % 3 == 0) pll_clk <= ~pll_clk;
		if (cyc > 20000) begin
			fail_count++;
			end_sim();
		end
	end

	// Phase length in cycles: crystal ticks every 4 cycles, PLL ticks every 6.
	function automatic int plen(mcp_pkg::mcp_cfg_s c, logic hi);
		return (c.clk_sel ? 6 : 4) * (int'(hi ? c.hi_div : c.lo_div) + 1);
	endfunction : plen

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (exp !== got) begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	// Small dividers keep periods short; channels 0 to 2 form the group when asked.
	task automatic setall(logic en, logic single, logic sm);
		@(posedge clk);
		for (int k = 0; k < 6; k++) begin
			cfg[k] <= '{en, single, k[0], sm && k < 3, 16'($urandom_range(5)),
				16'($urandom_range(5))};
		end
	endtask : setall

	// An inverted odd output swaps its high and low phases.
	task automatic chk_len();
		for (int k = 0; k < 6; k++) begin
			chk("high phase", plen(cfg[k], !(k[0] && pair_inv[k/2])), hi_len[k]);
			chk("low phase", plen(cfg[k], k[0] && pair_inv[k/2]), lo_len[k]);
		end
	endtask : chk_len

	task automatic end_sim();
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	// Main sequence: free running, single pulses, idle inversion, group update.
	initial begin
		{rstn, pll_clk, xo_clk, sync_load, trig, pair_inv, cfg} = '0;
		void'($urandom(20468));
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			setall(1, 0, 0);
			pair_inv <= r ? 3'h7 : 3'h0;
			repeat (400) @(posedge clk);
			#1;
			chk_len();
		end
		setall(0, 1, 0);
		pair_inv <= 3'h0;
		setall(1, 1, 0);
		repeat (4) @(posedge clk);
		#1;
		r0 = rises;
		// The second trigger lands while the pulse is still running.
		repeat (2) begin
			@(posedge clk);
			trig <= 6'h3F;
			@(posedge clk);
			trig <= 6'h00;
			repeat (2) @(posedge clk);
		end
		repeat (200) @(posedge clk);
		#1;
		for (int k = 0; k < 6; k++) chk("pulse count", r0[k] + 1, rises[k]);
		chk("rest level", 6'h00, pwm_out);
		chk("busy", 6'h00, busy);
		setall(0, 0, 0);
		pair_inv <= 3'h7;
		repeat (3) @(posedge clk);
		#1;
		chk("idle inverted", 6'h2A, pwm_out);
		pair_inv <= 3'h0;
		setall(0, 0, 1);
		sync_load <= 1'b1;
		@(posedge clk);
		sync_load <= 1'b0;
		setall(1, 0, 1);
		repeat (100) @(posedge clk);
		// New live dividers reach the members only through the group load.
		setall(1, 0, 1);
		sync_load <= 1'b1;
		@(posedge clk);
		sync_load <= 1'b0;
		#1;
		chk("group armed", 1, sync_busy);
		for (n = 0; n < 300 && sync_busy === 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk("group released", 0, sync_busy);
		chk("members parked", 3'h0, pwm_out[2:0]);
		repeat (2) @(posedge clk);
		#1;
		chk("members restart", 3'h7, pwm_out[2:0]);
		repeat (400) @(posedge clk);
		#1;
		chk_len();
		end_sim();
	end
endmodule : testbench
